// ==== rtl/rxeq_consts.svh ====
/*
 * Constants for the receive line equalizer control register bank:
 * register offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the modules; the package does not include it.
 */
// Functional notes
// - Short-line freeze stops equalizer updates when signal is near -15 dB or stronger.
// - Gain window field picks AGC update period: 32, 128, 512, 2048 bits.
// - Coefficient freeze holds coefficients; gain control keeps working.
// - Out-of-range block stops attenuator switching while converter is out of range.
// - Attenuator enable 0 forces attenuator off; 1 allows automatic use.
// - Eye-open timeout is 4096 bit times, or 8192 when the bit is set.
// - Six-bit gain ceiling caps amplifier gain; default 0x3F or 0x2F by variant.
// - Attenuator inactive below about -8 dB or when its enable is 0.
// - Pre-equalizer inactive above about -24 dB or when forced off (10XXXXXX).
// - Six-bit pointer indexes 48-byte coefficient table via the data register.
// - Slicer register: gain max 7:6, gain min 5:4, slicer threshold 3:0.
// - Acquisition error code picks 13/19/26/32 percent; restart when exceeded.
// - Operation error code, default 19 percent; restart when exceeded.
// - Four-bit target level sets pulse height target; default 68 percent.
// - Write gain status register first; write refreshes latch the read returns.
// - Gain status reports six-bit code, 0x3F is maximum gain.
// - Seven-bit recovery filter gain sets loop jitter tolerance.
// - Pre_equalizer_control control: force 0 auto, force+on forced on, force only forced off.
`ifndef RXEQ_CONSTS_SVH
`define RXEQ_CONSTS_SVH

// Register offsets
`define RXEQ_A_CFG 8'h22
`define RXEQ_A_LPF 8'h23
`define RXEQ_A_CEIL 8'h24
`define RXEQ_A_CDAT 8'h25
`define RXEQ_A_CPTR 8'h26
`define RXEQ_A_SLICE 8'h27
`define RXEQ_A_TGT 8'h28
`define RXEQ_A_GAIN 8'h29
`define RXEQ_A_PREEQ 8'h2a

// Field positions in the line configuration register
`define RXEQ_B_SHORT 7
`define RXEQ_B_HICLK 6
`define RXEQ_B_AGC_HI 5
`define RXEQ_B_AGC_LO 4
`define RXEQ_B_CFRZ 3
`define RXEQ_B_OOR 2
`define RXEQ_B_ATT 1
`define RXEQ_B_EYE 0
// Pre-equalizer control fields
`define RXEQ_B_FORCE 7
`define RXEQ_B_ON 6

// Reset values
`define RXEQ_R_CFG 8'h31
`define RXEQ_R_LPF 8'h40
`define RXEQ_R_CEIL_FULL 8'h3f
`define RXEQ_R_CEIL_SHORT 8'h2f
`define RXEQ_R_CDAT 8'h00
`define RXEQ_R_CPTR 8'h00
`define RXEQ_R_SLICE 8'h00
`define RXEQ_R_TGT 8'hda
`define RXEQ_R_PREEQ 8'h00

// Writable bit masks, reserved bits are zero
`define RXEQ_M_LPF 8'h7f
`define RXEQ_M_SIX 8'h3f

// Table size
`define RXEQ_TBL_DEPTH 48
`define RXEQ_PTR_LIMIT 6'd48

// Gain window lengths in bit times
`define RXEQ_AGC_W0 14'd32
`define RXEQ_AGC_W1 14'd128
`define RXEQ_AGC_W2 14'd512
`define RXEQ_AGC_W3 14'd2048
// Eye-open timeouts in bit times
`define RXEQ_EYE_SHORT 14'd4096
`define RXEQ_EYE_LONG 14'd8192

// Error tolerances as fractions of 256 full scale
`define RXEQ_ERR_13 8'd33
`define RXEQ_ERR_19 8'd49
`define RXEQ_ERR_26 8'd67
`define RXEQ_ERR_32 8'd82

`endif

// ==== rtl/rxeq_pkg.sv ====
/*
 * Types for the receive line equalizer control register bank.
 * Assumes rxeq_consts.svh is on the include path.
 */
package rxeq_pkg;

    // Analog front end status, synchronous to clk
    typedef struct packed {
        logic bit_tick;        // One pulse per line bit time
        logic level_ge_m15;    // Signal at about -15 dB or stronger
        logic level_ge_m8;     // Signal at about -8 dB or stronger
        logic level_le_m24;    // Signal at about -24 dB or weaker
        logic adc_out_of_range;
        logic att_request;     // Automatic attenuator wants engagement
        logic eye_open;
        logic eq_operating;    // 1 operation state, 0 acquisition
        logic [7:0] avg_error; // Average error, 256 is full scale
        logic [5:0] vga_gain;  // Live amplifier gain code
    } rxeq_line_stat_t;

    // Controls toward the analog front end
    typedef struct packed {
        logic coef_update_en;
        logic high_clock_slicer;
        logic rx_line_attenuator;
        logic pre_equalizer_control_active;
        logic [5:0] pre_equalizer_control_threshold;
        logic [5:0] gain_ceiling;
        logic [6:0] recovery_filter_gain;
        logic [7:0] slicer_limits;
        logic [3:0] target_level;
        logic agc_update;      // Pulse at end of each gain window
        logic eq_restart;      // Pulse restarting the equalizer
    } rxeq_ctrl_t;

endpackage : rxeq_pkg

// ==== rtl/rxeq_interval.sv ====
/*
 * Bit-time interval counter: pulses done after limit bit ticks.
 * Assumes tick is a one-cycle pulse synchronous to clk.
 */
`timescale 1ns/1ns
`include "rxeq_consts.svh"

module rxeq_interval import rxeq_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic restart,
    input wire logic tick,
    input wire logic [13:0] limit,
    output logic done
);

    logic [13:0] cnt_r;
    logic [13:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    // Count ticks, wrap and pulse at the limit
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (restart) begin
            cnt_nxt = 14'h0000;
        end else if (tick) begin
            if (cnt_r >= limit - 14'h0001) begin
                cnt_nxt = 14'h0000;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 14'h0000;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;

endmodule : rxeq_interval

// ==== rtl/rxeq_regs.sv ====
/*
 * Receive line equalizer control and status register bank with the
 * control logic it steers toward the analog front end.
 * Assumes a synchronous 8-bit host port (one-cycle rd/wr strobes) and
 * line status inputs synchronous to clk.
 */
`timescale 1ns/1ns
`include "rxeq_consts.svh"

module rxeq_regs import rxeq_pkg::*; #(
    parameter bit FULL_FEATURED = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic line_interface_reset,
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire rxeq_line_stat_t line_stat,
    output rxeq_ctrl_t ctrl
);

    // ***********************************************************
    // Declarations
    // ***********************************************************
    localparam logic [7:0] CEIL_RST = FULL_FEATURED ?
        `RXEQ_R_CEIL_FULL : `RXEQ_R_CEIL_SHORT;

    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] lpf_r, lpf_nxt;
    logic [7:0] ceil_r, ceil_nxt;
    logic [7:0] cptr_r, cptr_nxt;
    logic [7:0] slice_r, slice_nxt;
    logic [7:0] tgt_r, tgt_nxt;
    logic [7:0] preeq_r, preeq_nxt;
    logic [7:0] gain_r, gain_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] tbl_r [`RXEQ_TBL_DEPTH];
    logic [7:0] tbl_rd;
    logic ptr_ok;
    logic wr_cdat;
    rxeq_ctrl_t ctrl_r, ctrl_nxt;
    logic [13:0] agc_limit;
    logic [13:0] eye_limit;
    logic agc_done;
    logic eye_done;
    logic [7:0] err_thr;
    logic err_over;

    // ***********************************************************
    // Configuration registers
    // ***********************************************************

    // Host writes, reserved bits masked to zero
    always_comb begin
        cfg_nxt = cfg_r;
        lpf_nxt = lpf_r;
        ceil_nxt = ceil_r;
        cptr_nxt = cptr_r;
        slice_nxt = slice_r;
        tgt_nxt = tgt_r;
        preeq_nxt = preeq_r;
        if (line_interface_reset) begin
            cfg_nxt = `RXEQ_R_CFG;
            lpf_nxt = `RXEQ_R_LPF;
            ceil_nxt = CEIL_RST;
            cptr_nxt = `RXEQ_R_CPTR;
            slice_nxt = `RXEQ_R_SLICE;
            tgt_nxt = `RXEQ_R_TGT;
            preeq_nxt = `RXEQ_R_PREEQ;
        end else if (host_wr) begin
            case (host_addr)
                `RXEQ_A_CFG: cfg_nxt = host_wdata;
                `RXEQ_A_LPF: lpf_nxt = host_wdata & `RXEQ_M_LPF;
                `RXEQ_A_CEIL: ceil_nxt = host_wdata & `RXEQ_M_SIX;
                `RXEQ_A_CPTR: cptr_nxt = host_wdata & `RXEQ_M_SIX;
                `RXEQ_A_SLICE: slice_nxt = host_wdata;
                `RXEQ_A_TGT: tgt_nxt = host_wdata;
                `RXEQ_A_PREEQ: preeq_nxt = host_wdata;
                default: cfg_nxt = cfg_r;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= `RXEQ_R_CFG;
            lpf_r <= `RXEQ_R_LPF;
            ceil_r <= CEIL_RST;
            cptr_r <= `RXEQ_R_CPTR;
            slice_r <= `RXEQ_R_SLICE;
            tgt_r <= `RXEQ_R_TGT;
            preeq_r <= `RXEQ_R_PREEQ;
        end else begin
            cfg_r <= cfg_nxt;
            lpf_r <= lpf_nxt;
            ceil_r <= ceil_nxt;
            cptr_r <= cptr_nxt;
            slice_r <= slice_nxt;
            tgt_r <= tgt_nxt;
            preeq_r <= preeq_nxt;
        end
    end

    // ***********************************************************
    // Coefficient table
    // ***********************************************************

    // Pointer beyond the table reads zero and ignores writes
    assign ptr_ok = cptr_r[5:0] < `RXEQ_PTR_LIMIT;
    assign wr_cdat = host_wr && (host_addr == `RXEQ_A_CDAT) && ptr_ok;
    assign tbl_rd = ptr_ok ? tbl_r[cptr_r[5:0]] : 8'h00;

    // One register per table entry
    genvar gi;
    generate
        for (gi = 0; gi < `RXEQ_TBL_DEPTH; gi++) begin : g_tbl
            logic [7:0] ent_nxt;
            always_comb begin
                ent_nxt = tbl_r[gi];
                if (line_interface_reset) begin
                    ent_nxt = `RXEQ_R_CDAT;
                end else if (wr_cdat && (cptr_r[5:0] == 6'(gi))) begin
                    ent_nxt = host_wdata;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tbl_r[gi] <= `RXEQ_R_CDAT;
                end else begin
                    tbl_r[gi] <= ent_nxt;
                end
            end
        end
    endgenerate

    // ***********************************************************
    // Gain status latch
    // ***********************************************************

    // A write to the gain register refreshes the snapshot the next read returns
    always_comb begin
        gain_nxt = gain_r;
        if (line_interface_reset) begin
            gain_nxt = 8'h00;
        end else if (host_wr && (host_addr == `RXEQ_A_GAIN)) begin
            gain_nxt = {2'b00, line_stat.vga_gain};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gain_r <= 8'h00;
        end else begin
            gain_r <= gain_nxt;
        end
    end

    // ***********************************************************
    // Read port
    // ***********************************************************

    // Registered read data, unmapped offsets read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (host_rd) begin
            case (host_addr)
                `RXEQ_A_CFG: rdata_nxt = cfg_r;
                `RXEQ_A_LPF: rdata_nxt = lpf_r;
                `RXEQ_A_CEIL: rdata_nxt = ceil_r;
                `RXEQ_A_CDAT: rdata_nxt = tbl_rd;
                `RXEQ_A_CPTR: rdata_nxt = cptr_r;
                `RXEQ_A_SLICE: rdata_nxt = slice_r;
                `RXEQ_A_TGT: rdata_nxt = tgt_r;
                `RXEQ_A_GAIN: rdata_nxt = gain_r;
                `RXEQ_A_PREEQ: rdata_nxt = preeq_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ***********************************************************
    // Window and timeout counters
    // ***********************************************************

    // Gain window length from the two-bit field
    always_comb begin
        case (cfg_r[`RXEQ_B_AGC_HI:`RXEQ_B_AGC_LO])
            2'b00: agc_limit = `RXEQ_AGC_W0;
            2'b01: agc_limit = `RXEQ_AGC_W1;
            2'b10: agc_limit = `RXEQ_AGC_W2;
            default: agc_limit = `RXEQ_AGC_W3;
        endcase
    end

    // Eye-open timeout length
    assign eye_limit = cfg_r[`RXEQ_B_EYE] ?
        `RXEQ_EYE_LONG : `RXEQ_EYE_SHORT;

    // Gain windows run regardless of coefficient freeze
    rxeq_interval u_agc (
        .clk(clk),
        .nrst(nrst),
        .restart(line_interface_reset),
        .tick(line_stat.bit_tick),
        .limit(agc_limit),
        .done(agc_done)
    );

    // Timeout counts bit times while the eye stays closed
    rxeq_interval u_eye (
        .clk(clk),
        .nrst(nrst),
        .restart(line_interface_reset | line_stat.eye_open),
        .tick(line_stat.bit_tick),
        .limit(eye_limit),
        .done(eye_done)
    );

    // ***********************************************************
    // Error threshold compare
    // ***********************************************************

    // Tolerance by state: acquisition 7:6, operation 5:4
    always_comb begin
        logic [1:0] code;
        code = line_stat.eq_operating ? tgt_r[5:4] : tgt_r[7:6];
        case (code)
            2'b00: err_thr = `RXEQ_ERR_13;
            2'b01: err_thr = `RXEQ_ERR_19;
            2'b10: err_thr = `RXEQ_ERR_26;
            default: err_thr = `RXEQ_ERR_32;
        endcase
    end

    assign err_over = line_stat.eye_open &&
        (line_stat.avg_error > err_thr);

    // ***********************************************************
    // Front end controls
    // ***********************************************************

    // Next control values, all outputs registered
    always_comb begin
        ctrl_nxt = ctrl_r;
        // Coefficient updates under both freezes
        ctrl_nxt.coef_update_en = !cfg_r[`RXEQ_B_CFRZ] &&
            !(cfg_r[`RXEQ_B_SHORT] && line_stat.level_ge_m15);
        ctrl_nxt.high_clock_slicer = cfg_r[`RXEQ_B_HICLK];
        // Attenuator: forced off, held while out of range, else auto
        if (!cfg_r[`RXEQ_B_ATT]) begin
            ctrl_nxt.rx_line_attenuator = 1'b0;
        end else if (cfg_r[`RXEQ_B_OOR] && line_stat.adc_out_of_range) begin
            ctrl_nxt.rx_line_attenuator = ctrl_r.rx_line_attenuator;
        end else begin
            ctrl_nxt.rx_line_attenuator = line_stat.att_request &&
                line_stat.level_ge_m8;
        end
        // Pre-equalizer: forced state or automatic on weak lines
        if (preeq_r[`RXEQ_B_FORCE]) begin
            ctrl_nxt.pre_equalizer_control_active = preeq_r[`RXEQ_B_ON];
        end else begin
            ctrl_nxt.pre_equalizer_control_active = line_stat.level_le_m24;
        end
        ctrl_nxt.pre_equalizer_control_threshold = preeq_r[5:0];
        ctrl_nxt.gain_ceiling = ceil_r[5:0];
        ctrl_nxt.recovery_filter_gain = lpf_r[6:0];
        ctrl_nxt.slicer_limits = slice_r;
        ctrl_nxt.target_level = tgt_r[3:0];
        ctrl_nxt.agc_update = agc_done;
        ctrl_nxt.eq_restart = eye_done || err_over;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign host_rdata = rdata_r;
    assign ctrl = ctrl_r;

endmodule : rxeq_regs

// ==== tb/rxeq_checker.sv ====
/*
 * Port-level assertions for the equalizer control register bank.
 * Assumes binding into rxeq_regs; shadows two registers from writes.
 */
`timescale 1ns/1ns
`include "rxeq_consts.svh"

module rxeq_checker import rxeq_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic line_interface_reset,
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire rxeq_line_stat_t line_stat,
    input wire rxeq_ctrl_t ctrl
);
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [7:0] tgt_r;
    logic [7:0] tgt_nxt;
    logic [1:0] sel;
    logic [7:0] thr;
    logic blk;

    // ************************************************
    // Shadow copies of config and target registers
    // ************************************************
    always_comb begin
        cfg_nxt = cfg_r;
        tgt_nxt = tgt_r;
        if (line_interface_reset) begin
            cfg_nxt = 8'h31;
            tgt_nxt = 8'hda;
        end else if (host_wr && host_addr == `RXEQ_A_CFG) begin
            cfg_nxt = host_wdata;
        end else if (host_wr && host_addr == `RXEQ_A_TGT) begin
            tgt_nxt = host_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= 8'h31;
            tgt_r <= 8'hda;
        end else begin
            cfg_r <= cfg_nxt;
            tgt_r <= tgt_nxt;
        end
    end

    // Error tolerance in force for the current state
    always_comb begin
        sel = line_stat.eq_operating ? tgt_r[5:4] : tgt_r[7:6];
        case (sel)
            2'h0: thr = 8'h21;
            2'h1: thr = 8'h31;
            2'h2: thr = 8'h43;
            default: thr = 8'h52;
        endcase
        blk = cfg_r[2] && cfg_r[1] && line_stat.adc_out_of_range;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ************************************************
    // Assertions
    // ************************************************
    a_rdata_hold: assert property (!host_rd && !line_interface_reset
        |=> $stable(host_rdata)) else $error("read data moved");
    a_unmapped_zero: assert property (host_rd &&
        (host_addr < 8'h22 || host_addr > 8'h2a) |=> host_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_gain_refresh: assert property (host_wr &&
        host_addr == `RXEQ_A_GAIN && !line_interface_reset ##1
        host_rd && host_addr == `RXEQ_A_GAIN && !line_interface_reset
        |=> host_rdata == {2'h0, $past(line_stat.vga_gain, 2)})
        else $error("gain snapshot wrong");
    a_coef_frz: assert property (cfg_r[3] |=> !ctrl.coef_update_en)
        else $error("coefficients not frozen");
    a_short_frz: assert property (cfg_r[7] && line_stat.level_ge_m15
        |=> !ctrl.coef_update_en) else $error("short line not frozen");
    a_coef_run: assert property (!cfg_r[7] && !cfg_r[3]
        |=> ctrl.coef_update_en) else $error("updates stopped");
    a_att_block: assert property (blk
        |=> $stable(ctrl.rx_line_attenuator)) else $error("att switched");
    a_att_off: assert property (!cfg_r[1] && !blk
        |=> !ctrl.rx_line_attenuator) else $error("att not forced off");
    a_att_weak: assert property (!line_stat.level_ge_m8 && !blk
        |=> !ctrl.rx_line_attenuator) else $error("att on weak line");
    a_err_restart: assert property (line_stat.eye_open &&
        line_stat.avg_error > thr |=> ctrl.eq_restart)
        else $error("no restart on error");
    a_target_lvl: assert property (
        nrst |=> ctrl.target_level == $past(tgt_r[3:0]))
        else $error("target lost");

    // Main scenarios
    c_agc: cover property (ctrl.agc_update);
    c_restart: cover property (ctrl.eq_restart);
    c_block: cover property (blk && ctrl.rx_line_attenuator);
    c_gain: cover property (host_wr && host_addr == `RXEQ_A_GAIN ##1
        host_rd && host_addr == `RXEQ_A_GAIN);
endmodule : rxeq_checker

bind rxeq_regs rxeq_checker chk (
    .clk, .nrst, .line_interface_reset, .host_addr, .host_wr,
    .host_rd, .host_wdata, .host_rdata, .line_stat, .ctrl
);

// ==== tb/rxeq_tb.sv ====
/*
 * Self-checking bench for the equalizer control register bank.
 * Assumes the checker is compiled alongside and bound to the design.
 */
`timescale 1ns/1ns
`include "rxeq_consts.svh"

`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("BAD %0t got %0h want %0h", $time, g, e); \
    end \
end

module testbench import rxeq_pkg::*; ();
    logic clk;
    logic nrst;
    logic lir;
    logic [7:0] host_addr;
    logic host_wr;
    logic host_rd;
    logic [7:0] host_wdata;
    logic [7:0] host_rdata;
    rxeq_line_stat_t ls;
    rxeq_ctrl_t ctrl;
    int error_cnt = 0;
    int checks_done = 0;

    rxeq_regs uut (.clk(clk), .nrst(nrst), .line_interface_reset(lir),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .line_stat(ls), .ctrl(ctrl));

    // ************************************************
    // Clock and bus helpers
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic nx();
        @(posedge clk);
        #1;
    endtask : nx

    // Idle edge first, so back-to-back writes always drop the strobe for one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        nx();
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        nx();
        host_wr = 1'b0;
    endtask : wr

    // Read strobe, then one idle edge so the latched data has settled
    task automatic ck(input logic [7:0] a, input logic [7:0] e);
        host_addr = a;
        host_rd = 1'b1;
        nx();
        host_rd = 1'b0;
        nx();
        `CHK(host_rdata, e)
    endtask : ck

    task automatic lreset();
        lir = 1'b1;
        nx();
        lir = 1'b0;
    endtask : lreset

    // Sends bit ticks three cycles apart until the chosen pulse shows
    task automatic ticks(input bit agc, input int lim, output int n);
        bit hit;
        n = 0;
        hit = 0;
        while (!hit && n < lim) begin
            ls.bit_tick = 1'b1;
            nx();
            ls.bit_tick = 1'b0;
            n++;
            for (int k = 0; k < 3; k++) begin
                if (k > 0) nx();
                if ((agc ? ctrl.agc_update : ctrl.eq_restart) === 1'b1)
                    hit = 1;
            end
        end
    endtask : ticks

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_defaults();
        ck(`RXEQ_A_CFG, 8'h31);
        ck(`RXEQ_A_LPF, 8'h40);
        ck(`RXEQ_A_CEIL, 8'h3f);
        ck(`RXEQ_A_CPTR, 8'h00);
        ck(`RXEQ_A_CDAT, 8'h00);
        ck(`RXEQ_A_SLICE, 8'h00);
        ck(`RXEQ_A_TGT, 8'hda);
        ck(`RXEQ_A_PREEQ, 8'h00);
        ck(8'h21, 8'h00);
        ck(8'h2b, 8'h00);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_rw();
        wr(`RXEQ_A_LPF, 8'hff);
        wr(`RXEQ_A_CEIL, 8'hde);
        wr(`RXEQ_A_SLICE, 8'ha5);
        wr(8'h30, 8'hff);
        ck(`RXEQ_A_LPF, 8'h7f);
        ck(`RXEQ_A_CEIL, 8'h1e);
        ck(`RXEQ_A_SLICE, 8'ha5);
        ck(8'h30, 8'h00);
        `CHK(ctrl.recovery_filter_gain, 7'h7f)
        `CHK(ctrl.gain_ceiling, 6'h1e)
        `CHK(ctrl.slicer_limits, 8'ha5)
        $display("test rw done");
    endtask : t_rw

    task automatic t_table();
        wr(`RXEQ_A_CPTR, 8'hef);
        wr(`RXEQ_A_CDAT, 8'ha5);
        wr(`RXEQ_A_CPTR, 8'h00);
        wr(`RXEQ_A_CDAT, 8'h3c);
        ck(`RXEQ_A_CDAT, 8'h3c);
        ck(`RXEQ_A_CPTR, 8'h00);
        wr(`RXEQ_A_CPTR, 8'h2f);
        ck(`RXEQ_A_CDAT, 8'ha5);
        wr(`RXEQ_A_CPTR, 8'h30);
        wr(`RXEQ_A_CDAT, 8'h77);
        ck(`RXEQ_A_CDAT, 8'h00);
        lreset();
        ck(`RXEQ_A_CPTR, 8'h00);
        ck(`RXEQ_A_CDAT, 8'h00);
        ck(`RXEQ_A_LPF, 8'h40);
        ck(`RXEQ_A_SLICE, 8'h00);
        $display("test table done");
    endtask : t_table

    task automatic t_gain();
        ls.vga_gain = 6'h34;
        wr(`RXEQ_A_GAIN, 8'h00);
        ls.vga_gain = 6'h0f;
        ck(`RXEQ_A_GAIN, 8'h34);
        ck(`RXEQ_A_GAIN, 8'h34);
        ls.vga_gain = 6'h3f;
        wr(`RXEQ_A_GAIN, 8'hff);
        ck(`RXEQ_A_GAIN, 8'h3f);
        $display("test gain done");
    endtask : t_gain

    task automatic t_ctrl();
        ls.att_request = 1'b1;
        ls.level_ge_m8 = 1'b1;
        wr(`RXEQ_A_CFG, 8'h02);
        nx();
        `CHK(ctrl.rx_line_attenuator, 1'b1)
        `CHK(ctrl.coef_update_en, 1'b1)
        wr(`RXEQ_A_CFG, 8'h06);
        ls.adc_out_of_range = 1'b1;
        ls.att_request = 1'b0;
        nx();
        nx();
        `CHK(ctrl.rx_line_attenuator, 1'b1)
        ls.adc_out_of_range = 1'b0;
        nx();
        nx();
        `CHK(ctrl.rx_line_attenuator, 1'b0)
        ls.att_request = 1'b1;
        ls.level_ge_m8 = 1'b0;
        nx();
        nx();
        `CHK(ctrl.rx_line_attenuator, 1'b0)
        ls.level_ge_m8 = 1'b1;
        wr(`RXEQ_A_CFG, 8'h08);
        nx();
        `CHK(ctrl.rx_line_attenuator, 1'b0)
        `CHK(ctrl.coef_update_en, 1'b0)
        ls.level_ge_m15 = 1'b1;
        wr(`RXEQ_A_CFG, 8'hc0);
        nx();
        `CHK(ctrl.coef_update_en, 1'b0)
        `CHK(ctrl.high_clock_slicer, 1'b1)
        ls.level_ge_m15 = 1'b0;
        nx();
        nx();
        `CHK(ctrl.coef_update_en, 1'b1)
        ls.level_le_m24 = 1'b1;
        wr(`RXEQ_A_PREEQ, 8'hbf);
        nx();
        `CHK(ctrl.pre_equalizer_control_active, 1'b0)
        `CHK(ctrl.pre_equalizer_control_threshold, 6'h3f)
        wr(`RXEQ_A_PREEQ, 8'hc5);
        ls.level_le_m24 = 1'b0;
        nx();
        `CHK(ctrl.pre_equalizer_control_active, 1'b1)
        wr(`RXEQ_A_PREEQ, 8'h05);
        nx();
        `CHK(ctrl.pre_equalizer_control_active, 1'b0)
        ls.level_le_m24 = 1'b1;
        nx();
        nx();
        `CHK(ctrl.pre_equalizer_control_active, 1'b1)
        $display("test ctrl done");
    endtask : t_ctrl

    // Each code for both states, other state's field set the other way
    task automatic t_err();
        logic [7:0] th [4] = '{8'h21, 8'h31, 8'h43, 8'h52};
        logic [1:0] cc;
        ls.eye_open = 1'b1;
        for (int op = 0; op < 2; op++) begin
            ls.eq_operating = op[0];
            for (int c = 0; c < 4; c++) begin
                cc = c[1:0];
                ls.avg_error = th[c];
                wr(`RXEQ_A_TGT, op[0] ? {~cc, cc, 4'h9 + cc} :
                    {cc, ~cc, 4'h9 + cc});
                nx();
                nx();
                `CHK(ctrl.eq_restart, 1'b0)
                `CHK(ctrl.target_level, 4'h9 + cc)
                ls.avg_error = th[c] + 8'h01;
                nx();
                `CHK(ctrl.eq_restart, 1'b1)
            end
        end
        ls.avg_error = 8'h00;
        $display("test error thresholds done");
    endtask : t_err

    task automatic t_agc();
        int n;
        for (int c = 0; c < 4; c++) begin
            lreset();
            wr(`RXEQ_A_CFG, {2'h0, c[1:0], 4'h1});
            ticks(1'b1, 3000, n);
            `CHK(n, 32 << (2 * c))
        end
        $display("test gain window done");
    endtask : t_agc

    task automatic t_eye();
        int n;
        ls.eye_open = 1'b0;
        for (int b = 0; b < 2; b++) begin
            lreset();
            wr(`RXEQ_A_CFG, {7'h18, b[0]});
            ticks(1'b0, 9000, n);
            `CHK(n, 4096 << b)
        end
        ls.eye_open = 1'b1;
        $display("test eye timeout done");
    endtask : t_eye

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // ************************************************
    // Main sequence and watchdog
    // ************************************************
    initial begin
        nrst = 1'b0;
        lir = 1'b0;
        host_addr = 8'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
        ls = '0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_defaults();
        t_rw();
        t_table();
        t_gain();
        t_ctrl();
        t_err();
        t_agc();
        t_eye();
        stop_test();
    end

    initial begin
        #1000000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule : testbench
